// ===== hw/buck_mode_and_fault_control.sv
// Functional notes
// [RULE1] enter emulation after three negative pulses
// [RULE2] phase comparator latches after blanking, high-side low
// [RULE3] leave emulation after three positive pulses
// [RULE4] unlatched comparator means positive current
// [RULE5] audio filter pulses low side every 35us
// [RULE6] mode 1: select pin sets emulation, 130%
// [RULE7] mode 2: emulation on, 150%/130%, filter
// [RULE8] window step applied on entering emulation
// [RULE9] sample overcurrent every 15us, up/down count
// [RULE10] overcurrent fault when count reaches eight
// [RULE11] hard short latches overcurrent within 2us
// [RULE12] startup re-arm after sense 25mV below
// [RULE13] undervoltage held over 1ms latches fault
// [RULE14] overvoltage held over 1ms latches fault
// [RULE15] voltage detectors independent, use live reference
// [RULE16] fault: power-good low, both drives low
// [RULE17] faults clear on enable low or supply
// [RULE18] severe overvoltage: high-side off, low-side on
// [RULE19] low side toggles until supply reset only
// [RULE20] severe detector active despite other faults
// [RULE21] soft-start always continuous conduction
// [RULE22] power-good after 13 cycles in tolerance
// [RULE23] code msb selects mode 1 or 2
// [RULE24] timers count clock cycles, restart on clear
//
// Our own choices: the address map and register access over APB.
`default_nettype none
module buck_mode_and_fault_control #(
	parameter int UVOV_CYCLES = buck_ctrl_pkg::UVOV_CYC,
	parameter int UVOV_W      = 17
) (
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_pwm_high,
	input  wire logic        i_phase_positive,
	input  wire logic        i_overcurrent_cmp,
	input  wire logic        i_hard_short_cmp,
	input  wire logic        i_sense_rearm_cmp,
	input  wire logic        i_under_voltage_cmp,
	input  wire logic        i_over_voltage_cmp,
	input  wire logic        i_severe_high_cmp,
	input  wire logic        i_severe_low_cmp,
	input  wire logic        i_in_tolerance,
	input  wire logic        i_softstart_done,
	input  wire logic        i_emulation_select_pin,
	input  wire logic        i_filter_enable_pin,
	input  wire logic        i_regulator_enable_pin,
	input  wire logic [4:0]  i_voltage_id_code,
	input  wire logic        i_supply_ok,
	output logic             o_high_side_drive,
	output logic             o_low_side_drive,
	output logic             o_power_ok_out,
	output logic             o_power_ok_out_oe,
	output logic             o_diode_emulation_mode,
	output logic [1:0]       o_window_step
);
	localparam logic [10:0] TICK_LAST = 11'(buck_ctrl_pkg::OC_TICK_CYC - 1);
	localparam logic [11:0] AF_LAST   = 12'(buck_ctrl_pkg::AF_PERIOD_CYC - 1);
	localparam logic [4:0]  AF_WIDTH  = 5'(buck_ctrl_pkg::AF_PULSE_CYC);
	localparam logic [3:0]  BLANK     = 4'(buck_ctrl_pkg::BLANK_CYC);
	localparam logic [UVOV_W-1:0] UVOV_LIMIT = UVOV_W'(UVOV_CYCLES);

	typedef struct packed {
		logic              pwm_prev;
		logic              phase_latch;
		logic [3:0]        blank_cnt;
		logic [1:0]        neg_run;
		logic [1:0]        pos_run;
		logic              diode_emulation_mode;
		logic [10:0]       tick_cnt;
		logic [3:0]        oc_cnt;
		logic              oc_armed;
		logic              oc_fault;
		logic [UVOV_W-1:0] uv_cnt;
		logic [UVOV_W-1:0] ov_cnt;
		logic              uv_fault;
		logic              ov_fault;
		logic              sev_fault;
		logic              sev_ls;
		logic [11:0]       af_cnt;
		logic [4:0]        af_pulse;
		logic [3:0]        pg_cnt;
		logic              pg_pull_low;
		logic              hs;
		logic              ls;
		logic [1:0]        window;
		logic              force_ccm;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	logic       enabled;
	logic       mode2;
	logic       dem_allowed;
	logic       filter_sel;
	logic [1:0] window_sel;
	logic       any_fault;
	logic       pwm_rise;
	logic       pwm_fall;
	logic       ls_dem;

	always_comb begin
		nxt_state = state_ff;
		enabled = i_regulator_enable_pin && i_supply_ok;
		mode2 = i_voltage_id_code[4]; // [RULE23]
		pwm_rise = i_pwm_high && !state_ff.pwm_prev;
		pwm_fall = !i_pwm_high && state_ff.pwm_prev;
		any_fault = state_ff.oc_fault || state_ff.ov_fault || state_ff.uv_fault;

		// emulation permission, window and filter from pins and code
		if (!mode2) begin
			dem_allowed = i_emulation_select_pin; // [RULE6]
			window_sel = i_emulation_select_pin ? buck_ctrl_pkg::WIN_130
				: buck_ctrl_pkg::WIN_NOM;
			filter_sel = 1'b0;
		end else begin
			dem_allowed = 1'b1; // [RULE7]
			window_sel = i_filter_enable_pin ? buck_ctrl_pkg::WIN_130
				: buck_ctrl_pkg::WIN_150;
			filter_sel = i_filter_enable_pin && !i_emulation_select_pin;
		end
		// soft-start and software override keep continuous conduction
		dem_allowed = dem_allowed && i_softstart_done && !state_ff.force_ccm
			&& enabled; // [RULE21]

		nxt_state.pwm_prev = i_pwm_high;

		// phase comparator window: high-side low, after blanking
		if (pwm_fall) begin
			nxt_state.phase_latch = 1'b0;
			nxt_state.blank_cnt = BLANK;
		end else if (!i_pwm_high) begin
			if (state_ff.blank_cnt != 4'h0) begin
				nxt_state.blank_cnt = state_ff.blank_cnt - 4'h1;
			end else if (i_phase_positive) begin
				nxt_state.phase_latch = 1'b1; // [RULE2]
			end
		end

		// each new pulse judges the low interval just ended
		if (pwm_rise) begin
			if (state_ff.phase_latch) begin
				nxt_state.pos_run = 2'h0;
				if (state_ff.neg_run != buck_ctrl_pkg::MODE_RUN_COUNT) begin
					nxt_state.neg_run = state_ff.neg_run + 2'h1;
				end
			end else begin
				nxt_state.neg_run = 2'h0; // [RULE4]
				if (state_ff.pos_run != buck_ctrl_pkg::MODE_RUN_COUNT) begin
					nxt_state.pos_run = state_ff.pos_run + 2'h1;
				end
			end
			if (!state_ff.diode_emulation_mode && nxt_state.neg_run == buck_ctrl_pkg::MODE_RUN_COUNT
					&& dem_allowed) begin
				nxt_state.diode_emulation_mode = 1'b1; // [RULE1]
				nxt_state.neg_run = 2'h0;
				nxt_state.pos_run = 2'h0;
			end else if (state_ff.diode_emulation_mode
					&& nxt_state.pos_run == buck_ctrl_pkg::MODE_RUN_COUNT) begin
				nxt_state.diode_emulation_mode = 1'b0; // [RULE3]
				nxt_state.neg_run = 2'h0;
				nxt_state.pos_run = 2'h0;
			end
		end
		if (!dem_allowed) begin
			nxt_state.diode_emulation_mode = 1'b0;
		end

		// audio filter: timer restarts whenever the low side turns on
		if (!(state_ff.diode_emulation_mode && filter_sel) || state_ff.ls) begin
			nxt_state.af_cnt = 12'h000;
		end else if (state_ff.af_cnt == AF_LAST) begin
			nxt_state.af_cnt = 12'h000;
			nxt_state.af_pulse = AF_WIDTH; // [RULE5]
		end else begin
			nxt_state.af_cnt = state_ff.af_cnt + 12'h001;
		end
		if (state_ff.af_pulse != 5'h00) begin
			nxt_state.af_pulse = state_ff.af_pulse - 5'h01;
		end

		// overcurrent sampling, counter stays idle until re-armed
		if (i_sense_rearm_cmp) begin
			nxt_state.oc_armed = 1'b1; // [RULE12]
		end
		if (state_ff.tick_cnt == TICK_LAST) begin
			nxt_state.tick_cnt = 11'h000; // [RULE24]
			if (state_ff.oc_armed) begin
				if (i_overcurrent_cmp) begin
					nxt_state.oc_cnt = state_ff.oc_cnt + 4'h1; // [RULE9]
				end else if (state_ff.oc_cnt != 4'h0) begin
					nxt_state.oc_cnt = state_ff.oc_cnt - 4'h1;
				end
			end
		end else begin
			nxt_state.tick_cnt = state_ff.tick_cnt + 11'h001;
		end
		if (nxt_state.oc_cnt == buck_ctrl_pkg::OC_TRIP_COUNT) begin
			nxt_state.oc_fault = 1'b1; // [RULE10]
		end
		if (i_hard_short_cmp) begin
			nxt_state.oc_fault = 1'b1; // [RULE11]
		end

		// voltage qualification runs on its own, live reference
		if (!i_under_voltage_cmp) begin
			nxt_state.uv_cnt = '0; // [RULE24]
		end else if (state_ff.uv_cnt == UVOV_LIMIT) begin
			nxt_state.uv_fault = 1'b1; // [RULE13] [RULE15]
		end else begin
			nxt_state.uv_cnt = state_ff.uv_cnt + UVOV_W'(1);
		end
		if (!i_over_voltage_cmp) begin
			nxt_state.ov_cnt = '0;
		end else if (state_ff.ov_cnt == UVOV_LIMIT) begin
			nxt_state.ov_fault = 1'b1; // [RULE14] [RULE15]
		end else begin
			nxt_state.ov_cnt = state_ff.ov_cnt + UVOV_W'(1);
		end

		// severe overvoltage ignores other faults and the enable pin
		if (i_severe_high_cmp) begin
			nxt_state.sev_fault = 1'b1; // [RULE20]
			nxt_state.sev_ls = 1'b1; // [RULE18]
		end else if (i_severe_low_cmp) begin
			nxt_state.sev_ls = 1'b0; // [RULE19]
		end

		// power-good counts switching cycles once in tolerance
		if (!enabled || any_fault || state_ff.sev_fault || !i_in_tolerance) begin
			nxt_state.pg_cnt = 4'h0;
		end else if (pwm_rise && state_ff.pg_cnt != buck_ctrl_pkg::PG_CYCLES) begin
			nxt_state.pg_cnt = state_ff.pg_cnt + 4'h1; // [RULE22]
		end
		nxt_state.pg_pull_low = state_ff.pg_cnt != buck_ctrl_pkg::PG_CYCLES
			|| any_fault || state_ff.sev_fault || !enabled; // [RULE16] [RULE18]

		// without blocking, low side would sink negative current in emulation
		ls_dem = (!i_pwm_high && !state_ff.phase_latch) || state_ff.af_pulse != 5'h00;
		nxt_state.hs = enabled && !any_fault && !state_ff.sev_fault && i_pwm_high;
		if (state_ff.sev_fault) begin
			nxt_state.ls = state_ff.sev_ls; // [RULE19]
		end else if (any_fault || !enabled) begin
			nxt_state.ls = 1'b0; // [RULE16]
		end else begin
			nxt_state.ls = state_ff.diode_emulation_mode ? ls_dem : !i_pwm_high;
		end
		nxt_state.window = state_ff.diode_emulation_mode ? window_sel : buck_ctrl_pkg::WIN_NOM; // [RULE8]

		// regulator enable clears ordinary faults, supply clears all
		if (!enabled) begin
			nxt_state.oc_fault = 1'b0; // [RULE17]
			nxt_state.ov_fault = 1'b0;
			nxt_state.uv_fault = 1'b0;
			nxt_state.oc_cnt = 4'h0;
			nxt_state.oc_armed = 1'b0;
			nxt_state.uv_cnt = '0;
			nxt_state.ov_cnt = '0;
		end
		if (!i_supply_ok) begin
			nxt_state.sev_fault = 1'b0; // [RULE19]
			nxt_state.sev_ls = 1'b0;
		end

		// apb slave: ready in the first access cycle
		nxt_state.pready = i_psel && !i_penable;
		if (i_psel && !i_penable) begin
			nxt_state.pslverr = i_paddr != buck_ctrl_pkg::REG_CONTROL
				&& i_paddr != buck_ctrl_pkg::REG_STATUS;
			nxt_state.prdata = 32'h0000_0000;
			if (i_paddr == buck_ctrl_pkg::REG_CONTROL) begin
				nxt_state.prdata[buck_ctrl_pkg::CTRL_FORCE_CCM] = state_ff.force_ccm;
			end else if (i_paddr == buck_ctrl_pkg::REG_STATUS) begin
				nxt_state.prdata[buck_ctrl_pkg::ST_DEM] = state_ff.diode_emulation_mode;
				nxt_state.prdata[buck_ctrl_pkg::ST_OC_FAULT] = state_ff.oc_fault;
				nxt_state.prdata[buck_ctrl_pkg::ST_OV_FAULT] = state_ff.ov_fault;
				nxt_state.prdata[buck_ctrl_pkg::ST_UV_FAULT] = state_ff.uv_fault;
				nxt_state.prdata[buck_ctrl_pkg::ST_SEV_FAULT] = state_ff.sev_fault;
				nxt_state.prdata[buck_ctrl_pkg::ST_POWER_OK] = !state_ff.pg_pull_low;
				nxt_state.prdata[buck_ctrl_pkg::ST_WINDOW_LSB +: 2] = state_ff.window;
				nxt_state.prdata[buck_ctrl_pkg::ST_OC_COUNT_LSB +: 4] = state_ff.oc_cnt;
			end
		end
		if (i_psel && i_penable && state_ff.pready && i_pwrite
				&& i_paddr == buck_ctrl_pkg::REG_CONTROL) begin
			nxt_state.force_ccm = i_pwdata[buck_ctrl_pkg::CTRL_FORCE_CCM];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state_ff <= '0;
			state_ff.pg_pull_low <= 1'b1;
			state_ff.force_ccm <= buck_ctrl_pkg::CONTROL_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_prdata = state_ff.prdata;
	assign o_pready = state_ff.pready;
	assign o_pslverr = state_ff.pslverr;
	assign o_high_side_drive = state_ff.hs;
	assign o_low_side_drive = state_ff.ls;
	// open-drain pin only ever pulls low
	assign o_power_ok_out = 1'b0;
	assign o_power_ok_out_oe = state_ff.pg_pull_low;
	assign o_diode_emulation_mode = state_ff.diode_emulation_mode;
	assign o_window_step = state_ff.window;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	a_dem_entry_run: assert property ($rose(state_ff.diode_emulation_mode) |-> $past(state_ff.neg_run) == 2'h2
		&& $past(state_ff.phase_latch)) else $error("emulation entered early"); // [RULE1]
	a_dem_exit_run: assert property ($fell(state_ff.diode_emulation_mode) |-> $past(state_ff.pos_run) == 2'h2
		|| !$past(dem_allowed)) else $error("emulation left early"); // [RULE3]
	a_fault_drives: assert property ((any_fault && !state_ff.sev_fault) |=> !o_high_side_drive
		&& !o_low_side_drive && o_power_ok_out_oe) else $error("drive during fault"); // [RULE16]
	a_oc_count_trip: assert property ($rose(state_ff.oc_fault) |-> $past(state_ff.oc_cnt) == 4'h7
		|| $past(i_hard_short_cmp)) else $error("overcurrent trip count wrong"); // [RULE10]
	a_hard_short: assert property ((i_hard_short_cmp && enabled) |=> state_ff.oc_fault)
		else $error("hard short not latched"); // [RULE11]
	a_uv_qual_time: assert property ($rose(state_ff.uv_fault) |-> $past(state_ff.uv_cnt)
		== UVOV_LIMIT) else $error("undervoltage latched too soon"); // [RULE13]
	a_ov_qual_time: assert property ($rose(state_ff.ov_fault) |-> $past(state_ff.ov_cnt)
		== UVOV_LIMIT) else $error("overvoltage latched too soon"); // [RULE14]
	a_severe_trigger: assert property ((i_severe_high_cmp && i_supply_ok) |=> state_ff.sev_fault
		##1 (!o_high_side_drive && o_low_side_drive)) else $error("severe not handled"); // [RULE20]
	a_severe_hold: assert property ((state_ff.sev_fault && i_supply_ok) |=> state_ff.sev_fault)
		else $error("severe fault cleared"); // [RULE19]
	a_softstart_ccm: assert property (!i_softstart_done |=> !state_ff.diode_emulation_mode)
		else $error("emulation during soft-start"); // [RULE21]
	a_window_nominal: assert property (!state_ff.diode_emulation_mode |=> o_window_step == buck_ctrl_pkg::WIN_NOM)
		else $error("window raised outside emulation"); // [RULE8]

	c_enter_dem: cover property ($rose(state_ff.diode_emulation_mode));
	c_oc_trip: cover property ($rose(state_ff.oc_fault) && !i_hard_short_cmp);
	c_severe_toggle: cover property (state_ff.sev_fault && $fell(state_ff.sev_ls));
	c_power_good: cover property ($fell(o_power_ok_out_oe));
endmodule
`default_nettype wire

// ===== hw/buck_ctrl_pkg.sv
`default_nettype none
package buck_ctrl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// overcurrent sampling period
	localparam int OC_TICK_NS    = 15000;
	localparam int OC_TICK_CYC   = (OC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] OC_TRIP_COUNT = 4'h8;
	// under/over-voltage qualification time
	localparam int UVOV_US       = 1000;
	localparam int UVOV_CYC      = (UVOV_US * 1000) / CLK_PERIOD_NS;
	// audio filter pulse interval and width
	localparam int AF_PERIOD_NS  = 35000;
	localparam int AF_PERIOD_CYC = AF_PERIOD_NS / CLK_PERIOD_NS;
	localparam int AF_PULSE_NS   = 200;
	localparam int AF_PULSE_CYC  = (AF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// phase comparator blanking after high-side turn-off
	localparam int BLANK_NS      = 40;
	localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] MODE_RUN_COUNT = 2'h3;
	localparam logic [3:0] PG_CYCLES      = 4'hD;
	// window step selection
	localparam logic [1:0] WIN_NOM = 2'h0;
	localparam logic [1:0] WIN_130 = 2'h1;
	localparam logic [1:0] WIN_150 = 2'h2;
	// register map
	localparam logic [11:0] REG_CONTROL = 12'h000;
	localparam logic [11:0] REG_STATUS  = 12'h004;
	localparam int CTRL_FORCE_CCM  = 0;
	localparam int ST_DEM          = 0;
	localparam int ST_OC_FAULT     = 1;
	localparam int ST_OV_FAULT     = 2;
	localparam int ST_UV_FAULT     = 3;
	localparam int ST_SEV_FAULT    = 4;
	localparam int ST_POWER_OK     = 5;
	localparam int ST_WINDOW_LSB   = 6;
	localparam int ST_OC_COUNT_LSB = 8;
	localparam logic CONTROL_RESET = 1'b0;
endpackage
`default_nettype wire

// ===== dv/buck_plant.sv
`default_nettype none
module buck_plant (
	input  wire logic i_high_side_drive,
	input  wire logic i_neg_load,
	output logic      o_phase_positive
);
	timeunit 1ns;
	timeprecision 1ps;
	// phase sits at the rail while the high side conducts; negative inductor
	// current lifts it above ground whether the low side is on or not
	assign o_phase_positive = i_high_side_drive | i_neg_load;
endmodule
`default_nettype wire

// ===== dv/buck_mode_and_fault_control_tb.sv
`default_nettype none
module buck_mode_and_fault_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UVC = 50;
	localparam int TK = 1500;
	// {softstart done, vid msb, select, filter, force, dem, window}
	localparam logic [7:0] MODES [9] = '{8'h60, 8'hE8, 8'h80, 8'hA5, 8'hB5, 8'hC6, 8'hE6,
		8'hF5, 8'hD5};
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	logic        clock = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h3F1D;
	logic        pready, pslverr, hs, ls, oe, diode_emulation_mode, phase, neg = 1'h0, pwm = 1'h0;
	logic        oc = 1'h0, short = 1'h0, rearm = 1'h0, uv = 1'h0, ov = 1'h0;
	logic        sevh = 1'h0, sevl = 1'h0, tol = 1'h0, ssd = 1'h0, sel = 1'h0, af = 1'h0;
	logic        en = 1'h1, sup = 1'h1;
	logic [1:0]  win;
	logic [4:0]  vid = 5'h00;
	int          num_errors = 0, checks = 0;
	note_t       q[$];

	buck_mode_and_fault_control #(.UVOV_CYCLES(UVC)) u_dut (.i_clock(clock), .i_reset(reset),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_pwm_high(pwm), .i_phase_positive(phase), .i_overcurrent_cmp(oc),
		.i_hard_short_cmp(short), .i_sense_rearm_cmp(rearm), .i_under_voltage_cmp(uv),
		.i_over_voltage_cmp(ov), .i_severe_high_cmp(sevh), .i_severe_low_cmp(sevl),
		.i_in_tolerance(tol), .i_softstart_done(ssd), .i_emulation_select_pin(sel),
		.i_filter_enable_pin(af), .i_regulator_enable_pin(en), .i_voltage_id_code(vid),
		.i_supply_ok(sup), .o_high_side_drive(hs), .o_low_side_drive(ls),
		.o_power_ok_out(), .o_power_ok_out_oe(oe), .o_diode_emulation_mode(diode_emulation_mode),
		.o_window_step(win));
	buck_plant u_plant (.i_high_side_drive(hs), .i_neg_load(neg), .o_phase_positive(phase));

	always #5 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic fail(input logic [31:0] got, input logic [31:0] exp);
		num_errors++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic wrap_up();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// pins as {high, low, pull-low enable, emulation, window}
	task automatic cmp_pins(input logic [5:0] e);
		@(negedge clock);
		checks++;
		if ({hs, ls, oe, diode_emulation_mode, win} !== e) fail({26'h0, hs, ls, oe, diode_emulation_mode, win}, {26'h0, e});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [31:0] ed, input logic [31:0] em, input logic ee);
		int k;
		k = 0;
		q.push_back('{ed, em, ee});
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'h1;
		// request stands until the edge at which pready is seen high
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'h1 && k < 50);
		if (k >= 50) fail(32'h0, 32'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic st(input logic [31:0] ed, input logic [31:0] em);
		apb(1'h0, buck_ctrl_pkg::REG_STATUS, 32'h0, ed, em, 1'h0);
	endtask
	// the closing rise judges the last low interval
	task automatic pulses(input int n, input logic ng);
		repeat (n) begin
			rnd = xs(rnd);
			neg <= ng;
			pwm <= 1'h1;
			cyc(3 + rnd[1:0]);
			pwm <= 1'h0;
			cyc(10 + rnd[4:2]);
		end
		pwm <= 1'h1;
		cyc(3);
		pwm <= 1'h0;
		cyc(2);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// read results are judged when the answer shows, against the oldest note
	always @(posedge clock) begin
		note_t n;
		if (psel && penable && pready === 1'h1) begin
			n = q.pop_front();
			checks++;
			if ((prdata & n.m) !== n.d || pslverr !== n.e) fail(prdata, n.d);
		end
	end

	initial begin
		#(90000 * 10);
		num_errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		logic [7:0] m;
		int         k;
		cyc(5);
		reset <= 1'h0;
		cmp_pins(6'h08);
		rnd = xs(rnd);
		apb(1'h0, buck_ctrl_pkg::REG_CONTROL, 32'h0, 32'h0, 32'hFFFFFFFF, 1'h0);
		apb(1'h1, 12'h008, rnd, 32'h0, 32'h0, 1'h1);
		apb(1'h0, 12'h008, 32'h0, 32'h0, 32'hFFFFFFFF, 1'h1);
		apb(1'h1, buck_ctrl_pkg::REG_CONTROL, 32'h1, 32'h0, 32'h0, 1'h0);
		apb(1'h0, buck_ctrl_pkg::REG_CONTROL, 32'h0, 32'h1, 32'h1, 1'h0);
		done("registers");
		foreach (MODES[i]) begin
			m = MODES[i];
			rnd = xs(rnd);
			ssd <= m[7];
			vid <= {m[6], rnd[3:0]};
			sel <= m[5];
			af <= m[4];
			apb(1'h1, buck_ctrl_pkg::REG_CONTROL, {31'h0, m[3]}, 32'h0, 32'h0, 1'h0);
			pulses(4, 1'h1);
			st({24'h0, m[2] ? m[1:0] : 2'h0, 5'h0, m[2]}, 32'hC1);
			if (m[6] && !m[5] && m[4]) begin
				k = 0;
				do begin
					@(negedge clock);
					k++;
				end while (ls !== 1'h1 && k < 3700);
				checks++;
				if (k >= 3700) fail(k, 3500);
				cyc(25);
				cmp_pins(6'h0D);
			end
			pulses(4, 1'h0);
			st(32'h0, 32'hC1);
		end
		done("modes");
		tol <= 1'h1;
		pulses(11, 1'h0);
		st(32'h0, 32'h20);
		pulses(0, 1'h0);
		cmp_pins(6'h10);
		done("power good");
		for (int j = 0; j < 2; j++) begin
			{ov, uv} <= j ? 2'h2 : 2'h1;
			cyc(UVC - 10);
			{ov, uv} <= 2'h0;
			cyc(2);
			{ov, uv} <= j ? 2'h2 : 2'h1;
			cyc(UVC - 10);
			// power-good still released on the first pass, lost after the enable cycle
			st(j ? 32'h0 : 32'h20, 32'h3E);
			cyc(14);
			{ov, uv} <= 2'h0;
			pwm <= 1'h1;
			cyc(3);
			cmp_pins(6'h08);
			pwm <= 1'h0;
			st(j ? 32'h04 : 32'h08, 32'h3E);
			en <= 1'h0;
			cyc(2);
			en <= 1'h1;
			st(32'h0, 32'h1E);
		end
		short <= 1'h1;
		cyc(1);
		short <= 1'h0;
		pwm <= 1'h1;
		cyc(3);
		cmp_pins(6'h08);
		pwm <= 1'h0;
		st(32'h02, 32'h3E);
		en <= 1'h0;
		cyc(2);
		en <= 1'h1;
		done("voltage and short");
		oc <= 1'h1;
		cyc(2 * TK);
		st(32'h0, 32'hF02);
		rearm <= 1'h1;
		cyc(4 * TK);
		oc <= 1'h0;
		cyc(7 * TK);
		st(32'h0, 32'hF02);
		oc <= 1'h1;
		cyc(6 * TK);
		st(32'h0, 32'h02);
		cyc(2 * TK + 30);
		st(32'h02, 32'h3E);
		oc <= 1'h0;
		done("overcurrent");
		sevh <= 1'h1;
		cyc(3);
		cmp_pins(6'h18);
		st(32'h12, 32'h3E);
		sevh <= 1'h0;
		cyc(3);
		cmp_pins(6'h18);
		sevl <= 1'h1;
		cyc(3);
		cmp_pins(6'h08);
		sevl <= 1'h0;
		sevh <= 1'h1;
		en <= 1'h0;
		cyc(3);
		cmp_pins(6'h18);
		sevh <= 1'h0;
		sevl <= 1'h1;
		sup <= 1'h0;
		cyc(3);
		sup <= 1'h1;
		en <= 1'h1;
		cyc(3);
		st(32'h0, 32'h1E);
		done("severe");
		wrap_up();
	end
endmodule
`default_nettype wire
